// ===== pwm_ctrl_pkg.sv
// Package of register offsets, field positions and reset values for PWM module control
package pwm_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL_UPDATE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_TIME_BASE_RESET = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_GATE = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_POLARITY = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_FAULT_FORCING = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_IRQ_RAW = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS_CLEAR = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_FAULT_INPUT_STATE = 12'h020;
  localparam int BIT_GEN_ZERO = 0;
  localparam int BIT_FAULT_IRQ = 16;
  localparam int BIT_FAULT_STATE = 0;
  localparam int NUM_CH = 2;
  localparam logic [NUM_CH-1:0] CH_RESET = 2'h0;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// ===== pwm_module_output_control.sv
// PWM module-level control: update and sync requests, output stage, fault and interrupts
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module pwm_module_output_control
  import pwm_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fault_pin,
  input wire logic debug_stall,
  input wire logic gen_counter_zero,
  input wire logic gen_irq,
  input wire logic channel_a_signal,
  input wire logic channel_b_signal,
  output logic apply_pending_gen_zero,
  output logic update_request,
  output logic counter_restart_gen_zero,
  output logic fault_condition,
  output logic [NUM_CH-1:0] pwm_pin,
  output logic module_irq
);

  logic global_update_q, global_update_d;
  logic time_base_reset_q, time_base_reset_d;
  logic [NUM_CH-1:0] output_gate_q;
  logic [NUM_CH-1:0] output_polarity_q;
  logic [NUM_CH-1:0] fault_forcing_q;
  logic fault_irq_en_q, gen_irq_en_q;
  logic fault_irq_q, fault_irq_d;
  logic fault_meta_q, fault_sync_q;
  logic fault_prev_q;
  logic [NUM_CH-1:0] pin_q, pin_d;
  logic [31:0] rdata_q, rdata_d;

  wire logic wr_global = reg_wr && (reg_addr == OFF_GLOBAL_UPDATE);
  wire logic wr_sync = reg_wr && (reg_addr == OFF_TIME_BASE_RESET);
  wire logic wr_gate = reg_wr && (reg_addr == OFF_OUTPUT_GATE);
  wire logic wr_pol = reg_wr && (reg_addr == OFF_OUTPUT_POLARITY);
  wire logic wr_fault = reg_wr && (reg_addr == OFF_FAULT_FORCING);
  wire logic wr_inten = reg_wr && (reg_addr == OFF_IRQ_ENABLE);
  wire logic wr_isc = reg_wr && (reg_addr == OFF_IRQ_STATUS_CLEAR);
  wire logic fault_rise = fault_sync_q && !fault_prev_q;
  wire logic [NUM_CH-1:0] raw_ch = {channel_b_signal, channel_a_signal};
  wire logic [NUM_CH-1:0] gated = raw_ch & output_gate_q;
  wire logic [NUM_CH-1:0] forced = gated & ~({NUM_CH{fault_condition}} & fault_forcing_q);
  wire logic [31:0] raw_status = {15'h0000, fault_irq_q, 15'h0000, gen_irq};
  wire logic [31:0] masked_status = {15'h0000, fault_irq_q & fault_irq_en_q, 15'h0000,
    gen_irq & gen_irq_en_q};

  // Fault input and debug stall both count as fault
  // Stall also reaches the generator, which counts down to zero and stops there
  assign fault_condition = fault_sync_q || debug_stall;
  // Pass-through channels keep whatever the generator makes under debug
  assign pin_d = forced ^ output_polarity_q;

  // Update request held until the generator reaches zero
  assign global_update_d = (wr_global && reg_wdata[BIT_GEN_ZERO]) ? 1'b1 :
    (global_update_q && gen_counter_zero) ? 1'b0 : global_update_q;
  assign update_request = global_update_q;
  assign apply_pending_gen_zero = global_update_q && gen_counter_zero;
  // Reset strobe for one cycle, then bit clears
  assign time_base_reset_d = wr_sync && reg_wdata[BIT_GEN_ZERO];
  assign counter_restart_gen_zero = time_base_reset_q;
  // Latched fault, set wins over clear
  assign fault_irq_d = fault_rise ? 1'b1 :
    (wr_isc && reg_wdata[BIT_FAULT_IRQ]) ? 1'b0 : fault_irq_q;
  assign module_irq = (fault_irq_q && fault_irq_en_q) || (gen_irq && gen_irq_en_q);

  always_comb begin
    rdata_d = REG_RESET;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_GLOBAL_UPDATE: rdata_d = {31'h0000_0000, global_update_q};
        OFF_TIME_BASE_RESET: rdata_d = {31'h0000_0000, time_base_reset_q};
        OFF_OUTPUT_GATE: rdata_d = {30'h0000_0000, output_gate_q};
        OFF_OUTPUT_POLARITY: rdata_d = {30'h0000_0000, output_polarity_q};
        OFF_FAULT_FORCING: rdata_d = {30'h0000_0000, fault_forcing_q};
        OFF_IRQ_ENABLE: rdata_d = {15'h0000, fault_irq_en_q, 15'h0000, gen_irq_en_q};
        OFF_IRQ_RAW: rdata_d = raw_status;
        OFF_IRQ_STATUS_CLEAR: rdata_d = masked_status;
        OFF_FAULT_INPUT_STATE: rdata_d = {31'h0000_0000, fault_sync_q};
        default: rdata_d = REG_RESET;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  assign pwm_pin = pin_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_meta_q <= 1'b0;
      fault_sync_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      fault_meta_q <= fault_pin;
      fault_sync_q <= fault_meta_q;
      fault_prev_q <= fault_sync_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      global_update_q <= 1'b0;
      time_base_reset_q <= 1'b0;
      fault_irq_q <= 1'b0;
      pin_q <= CH_RESET;
      rdata_q <= REG_RESET;
    end else begin
      global_update_q <= global_update_d;
      time_base_reset_q <= time_base_reset_d;
      fault_irq_q <= fault_irq_d;
      pin_q <= pin_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      output_gate_q <= CH_RESET;
      output_polarity_q <= CH_RESET;
      fault_forcing_q <= CH_RESET;
    end else begin
      if (wr_gate) output_gate_q <= reg_wdata[NUM_CH-1:0];
      if (wr_pol) output_polarity_q <= reg_wdata[NUM_CH-1:0];
      if (wr_fault) fault_forcing_q <= reg_wdata[NUM_CH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_irq_en_q <= 1'b0;
      gen_irq_en_q <= 1'b0;
    end else if (wr_inten) begin
      fault_irq_en_q <= reg_wdata[BIT_FAULT_IRQ];
      gen_irq_en_q <= reg_wdata[BIT_GEN_ZERO];
    end
  end

  property p_update_clears;
    @(posedge core_clk) disable iff (rst)
      (global_update_q && gen_counter_zero && !(wr_global && reg_wdata[0])) |=> !global_update_q;
  endproperty
  a_update_clears: assert property (p_update_clears) else $error("update bit not cleared");

  property p_update_holds;
    @(posedge core_clk) disable iff (rst)
      (global_update_q && !gen_counter_zero) |=> global_update_q;
  endproperty
  a_update_holds: assert property (p_update_holds) else $error("update bit lost early");

  property p_sync_pulse;
    @(posedge core_clk) disable iff (rst)
      (wr_sync && reg_wdata[0]) |=> counter_restart_gen_zero ##1 (!counter_restart_gen_zero || $past(wr_sync));
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync strobe wrong");

  property p_pin_value;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> pwm_pin == ((($past(raw_ch) & $past(output_gate_q)) & ~({2{$past(fault_condition)}}
        & $past(fault_forcing_q))) ^ $past(output_polarity_q));
  endproperty
  a_pin_value: assert property (p_pin_value) else $error("pin value wrong");

  property p_fault_force;
    @(posedge core_clk) disable iff (rst)
      (fault_condition && fault_forcing_q[0]) |=> pwm_pin[0] == $past(output_polarity_q[0]);
  endproperty
  a_fault_force: assert property (p_fault_force) else $error("fault force wrong");

  property p_disabled_pol;
    @(posedge core_clk) disable iff (rst)
      (!output_gate_q[1]) |=> pwm_pin[1] == $past(output_polarity_q[1]);
  endproperty
  a_disabled_pol: assert property (p_disabled_pol) else $error("disabled polarity wrong");

  property p_fault_latch;
    @(posedge core_clk) disable iff (rst)
      (fault_irq_q && !(wr_isc && reg_wdata[16])) |=> fault_irq_q;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault latch lost");

  property p_irq_line;
    @(posedge core_clk) disable iff (rst)
      (gen_irq && gen_irq_en_q) |-> module_irq;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq not raised");

  property p_status_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == OFF_FAULT_INPUT_STATE) |=> reg_rdata[0] == $past(fault_sync_q);
  endproperty
  a_status_read: assert property (p_status_read) else $error("fault state read wrong");

  property p_update_sets;
    @(posedge core_clk) disable iff (rst)
      (wr_global && reg_wdata[BIT_GEN_ZERO]) |=> update_request;
  endproperty
  a_update_sets: assert property (p_update_sets) else $error("update request not set");

  property p_update_rise;
    @(posedge core_clk) disable iff (rst)
      $rose(update_request) |-> $past(wr_global && reg_wdata[BIT_GEN_ZERO]);
  endproperty
  a_update_rise: assert property (p_update_rise) else $error("update set without write");

  property p_apply_at_zero;
    @(posedge core_clk) disable iff (rst)
      (update_request && gen_counter_zero) |-> apply_pending_gen_zero;
  endproperty
  a_apply_at_zero: assert property (p_apply_at_zero) else $error("pending update not applied");

  property p_no_apply_idle;
    @(posedge core_clk) disable iff (rst)
      !update_request |-> !apply_pending_gen_zero;
  endproperty
  a_no_apply_idle: assert property (p_no_apply_idle) else $error("apply without request");

  property p_sync_sets;
    @(posedge core_clk) disable iff (rst)
      (wr_sync && reg_wdata[BIT_GEN_ZERO]) |=> counter_restart_gen_zero;
  endproperty
  a_sync_sets: assert property (p_sync_sets) else $error("restart not raised");

  property p_sync_only_write;
    @(posedge core_clk) disable iff (rst)
      counter_restart_gen_zero |-> $past(wr_sync && reg_wdata[BIT_GEN_ZERO]);
  endproperty
  a_sync_only_write: assert property (p_sync_only_write) else $error("restart without write");

  property p_sync_clears;
    @(posedge core_clk) disable iff (rst)
      (counter_restart_gen_zero && !wr_sync) |=> !counter_restart_gen_zero;
  endproperty
  a_sync_clears: assert property (p_sync_clears) else $error("sync bit not cleared");

  property p_sync_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == OFF_TIME_BASE_RESET) |=>
        reg_rdata[0] == $past(counter_restart_gen_zero);
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync bit read wrong");

  property p_gate_zero_a;
    @(posedge core_clk) disable iff (rst)
      !output_gate_q[0] |=> pwm_pin[0] == $past(output_polarity_q[0]);
  endproperty
  a_gate_zero_a: assert property (p_gate_zero_a) else $error("disabled channel a wrong");

  property p_pass_a;
    @(posedge core_clk) disable iff (rst)
      (output_gate_q[0] && !(fault_condition && fault_forcing_q[0])) |=>
        pwm_pin[0] == ($past(channel_a_signal) ^ $past(output_polarity_q[0]));
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("channel a pass wrong");

  property p_pass_b;
    @(posedge core_clk) disable iff (rst)
      (output_gate_q[1] && !(fault_condition && fault_forcing_q[1])) |=>
        pwm_pin[1] == ($past(channel_b_signal) ^ $past(output_polarity_q[1]));
  endproperty
  a_pass_b: assert property (p_pass_b) else $error("channel b pass wrong");

  property p_fault_force_b;
    @(posedge core_clk) disable iff (rst)
      (fault_condition && fault_forcing_q[1]) |=> pwm_pin[1] == $past(output_polarity_q[1]);
  endproperty
  a_fault_force_b: assert property (p_fault_force_b) else $error("fault force b wrong");

  property p_stall_fault;
    @(posedge core_clk) disable iff (rst)
      debug_stall |-> fault_condition;
  endproperty
  a_stall_fault: assert property (p_stall_fault) else $error("stall not a fault");

  property p_pin_fault_cond;
    @(posedge core_clk) disable iff (rst)
      fault_sync_q |-> fault_condition;
  endproperty
  a_pin_fault_cond: assert property (p_pin_fault_cond) else $error("fault input ignored");

  property p_no_fault_cond;
    @(posedge core_clk) disable iff (rst)
      (!fault_sync_q && !debug_stall) |-> !fault_condition;
  endproperty
  a_no_fault_cond: assert property (p_no_fault_cond) else $error("spurious fault");

  property p_fault_sync_delay;
    @(posedge core_clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2)) |-> fault_sync_q == $past(fault_pin, 2);
  endproperty
  a_fault_sync_delay: assert property (p_fault_sync_delay) else $error("fault sync wrong");

  property p_fault_irq_set;
    @(posedge core_clk) disable iff (rst)
      (fault_sync_q && !fault_prev_q) |=> fault_irq_q;
  endproperty
  a_fault_irq_set: assert property (p_fault_irq_set) else $error("fault irq not latched");

  property p_fault_irq_clear;
    @(posedge core_clk) disable iff (rst)
      (wr_isc && reg_wdata[BIT_FAULT_IRQ] && !fault_rise) |=> !fault_irq_q;
  endproperty
  a_fault_irq_clear: assert property (p_fault_irq_clear) else $error("fault irq not cleared");

  property p_fault_irq_rise;
    @(posedge core_clk) disable iff (rst)
      $rose(fault_irq_q) |-> $past(fault_rise);
  endproperty
  a_fault_irq_rise: assert property (p_fault_irq_rise) else $error("fault irq without fault");

  property p_raw_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == OFF_IRQ_RAW) |=>
        reg_rdata == {15'h0000, $past(fault_irq_q), 15'h0000, $past(gen_irq)};
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw status read wrong");

  property p_isc_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == OFF_IRQ_STATUS_CLEAR) |=>
        reg_rdata[BIT_GEN_ZERO] == $past(gen_irq && gen_irq_en_q);
  endproperty
  a_isc_read: assert property (p_isc_read) else $error("generator status read wrong");

  property p_irq_fault_line;
    @(posedge core_clk) disable iff (rst)
      (fault_irq_q && fault_irq_en_q) |-> module_irq;
  endproperty
  a_irq_fault_line: assert property (p_irq_fault_line) else $error("fault irq not raised");

  property p_irq_quiet;
    @(posedge core_clk) disable iff (rst)
      (!(fault_irq_q && fault_irq_en_q) && !(gen_irq && gen_irq_en_q)) |-> !module_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enabled source");

  property p_inten_write;
    @(posedge core_clk) disable iff (rst)
      wr_inten |=> {fault_irq_en_q, gen_irq_en_q} ==
        {$past(reg_wdata[BIT_FAULT_IRQ]), $past(reg_wdata[BIT_GEN_ZERO])};
  endproperty
  a_inten_write: assert property (p_inten_write) else $error("irq enable write wrong");

  property p_gate_write;
    @(posedge core_clk) disable iff (rst)
      wr_gate |=> output_gate_q == $past(reg_wdata[NUM_CH-1:0]);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write wrong");

  property p_pol_write;
    @(posedge core_clk) disable iff (rst)
      wr_pol |=> output_polarity_q == $past(reg_wdata[NUM_CH-1:0]);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write wrong");

  property p_force_write;
    @(posedge core_clk) disable iff (rst)
      wr_fault |=> fault_forcing_q == $past(reg_wdata[NUM_CH-1:0]);
  endproperty
  a_force_write: assert property (p_force_write) else $error("fault forcing write wrong");

endmodule

// ===== pwm_gen_model.sv
// Behavioural generator model feeding raw channels and the zero flag
`timescale 1ns/10ps
module pwm_gen_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic counter_restart_gen_zero,
  input wire logic debug_stall,
  output logic gen_counter_zero,
  output logic channel_a_signal,
  output logic channel_b_signal
);
  logic [2:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst || counter_restart_gen_zero) begin
      cnt_q <= 3'h0;
    end else if (!(debug_stall && cnt_q == 3'h0)) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign gen_counter_zero = (cnt_q == 3'h0);
  assign channel_a_signal = (cnt_q < 3'h3);
  assign channel_b_signal = cnt_q[0];
endmodule

// ===== pwm_module_output_control_test.sv
// Self-checking bench for the PWM module output control block
`timescale 1ns/10ps
module pwm_module_output_control_test
  import pwm_ctrl_pkg::*;
;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, fault_pin = 0, debug_stall = 0;
  logic gen_irq = 0, gen_zero, ch_a, ch_b, apply, upd, restart, fcond, module_irq;
  logic [ADDR_W-1:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [1:0] pwm_pin, gate_m = 0, pol_m = 0, force_m = 0, pin_exp = 0, fs = 0;
  int errors = 0, checked = 0, rs_cnt = 0, i, n;
  always #25 core_clk = ~core_clk;
  pwm_module_output_control u_pwm_module_output_control (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fault_pin(fault_pin), .debug_stall(debug_stall),
    .gen_counter_zero(gen_zero), .gen_irq(gen_irq), .channel_a_signal(ch_a),
    .channel_b_signal(ch_b), .apply_pending_gen_zero(apply), .update_request(upd),
    .counter_restart_gen_zero(restart), .fault_condition(fcond), .pwm_pin(pwm_pin),
    .module_irq(module_irq));
  pwm_gen_model u_pwm_gen_model (.core_clk(core_clk), .rst(rst),
    .counter_restart_gen_zero(restart), .debug_stall(debug_stall),
    .gen_counter_zero(gen_zero), .channel_a_signal(ch_a), .channel_b_signal(ch_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic irq_is(input logic exp);
    @(negedge core_clk) chk({31'h0, module_irq}, {31'h0, exp});
    @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reference model of the pin path, one cycle behind the inputs
  always @(posedge core_clk) begin
    fs <= {fs[0], fault_pin};
    if (restart) rs_cnt++;
    if (reg_wr && reg_addr == OFF_OUTPUT_GATE) gate_m <= reg_wdata[1:0];
    if (reg_wr && reg_addr == OFF_OUTPUT_POLARITY) pol_m <= reg_wdata[1:0];
    if (reg_wr && reg_addr == OFF_FAULT_FORCING) force_m <= reg_wdata[1:0];
    pin_exp <= (({ch_b, ch_a} & gate_m) & ~({2{fs[1] | debug_stall}} & force_m)) ^ pol_m;
  end
  always @(negedge core_clk) begin
    if (!rst) begin
      chk({30'h0, pwm_pin}, {30'h0, pin_exp});
      chk({31'h0, fcond}, {31'h0, fs[1] | debug_stall});
    end
  end
  initial begin
    #2000000;
    errors++;
    end_sim;
  end
  initial begin
    void'($urandom(30891));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 10; i++) rd(ADDR_W'(i * 4), 32'h0);
    wr(OFF_IRQ_RAW, 32'h0001_0001);
    wr(OFF_FAULT_INPUT_STATE, 32'h0000_0001);
    rd(OFF_IRQ_RAW, 32'h0);
    rd(OFF_FAULT_INPUT_STATE, 32'h0);
    wr(OFF_OUTPUT_GATE, 32'h0000_0003);
    rd(OFF_OUTPUT_GATE, 32'h3);
    $display("test registers done");
    for (i = 0; i < 40; i++) begin
      wr(OFF_OUTPUT_GATE, {30'h0, 2'($urandom)});
      wr(OFF_OUTPUT_POLARITY, {30'h0, 2'($urandom)});
      wr(OFF_FAULT_FORCING, {30'h0, 2'($urandom)});
      debug_stall <= 1'($urandom);
      repeat (4) @(posedge core_clk);
    end
    debug_stall <= 1'b0;
    $display("test output stage done");
    rs_cnt = 0;
    wr(OFF_TIME_BASE_RESET, 32'h1);
    @(posedge core_clk);
    chk(rs_cnt, 1);
    rd(OFF_TIME_BASE_RESET, 32'h0);
    while (u_pwm_gen_model.cnt_q !== 3'h7) @(posedge core_clk);
    wr(OFF_GLOBAL_UPDATE, 32'h1);
    wr(OFF_GLOBAL_UPDATE, 32'h0);
    rd(OFF_GLOBAL_UPDATE, 32'h1);
    for (n = 0; n < 20; n++) begin
      @(negedge core_clk);
      if (apply === 1'b1) break;
    end
    chk({29'h0, apply, gen_zero, upd}, 32'h7);
    @(negedge core_clk) chk({30'h0, apply, upd}, 32'h0);
    @(posedge core_clk);
    rd(OFF_GLOBAL_UPDATE, 32'h0);
    $display("test update and sync done");
    wr(OFF_IRQ_ENABLE, 32'h0001_0001);
    fault_pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(OFF_FAULT_INPUT_STATE, 32'h1);
    rd(OFF_IRQ_RAW, 32'h0001_0000);
    irq_is(1'b1);
    wr(OFF_IRQ_STATUS_CLEAR, 32'h0001_0000);
    rd(OFF_IRQ_STATUS_CLEAR, 32'h0);
    fault_pin <= 1'b0;
    gen_irq <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFF_IRQ_STATUS_CLEAR, 32'h1);
    wr(OFF_IRQ_ENABLE, 32'h0001_0000);
    irq_is(1'b0);
    rd(OFF_IRQ_RAW, 32'h1);
    wr(OFF_IRQ_STATUS_CLEAR, 32'h0000_0001);
    rd(OFF_IRQ_RAW, 32'h1);
    wr(OFF_IRQ_ENABLE, 32'h0);
    fault_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(OFF_IRQ_RAW, 32'h0001_0001);
    gen_irq <= 1'b0;
    irq_is(1'b0);
    $display("test interrupts done");
    end_sim;
  end
endmodule
